// >>> hw/osc_ctrl.sv
// Oscillator control block: locked control register, trim, failure handling, AXI4-Lite slave.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "osc_cfg.svh"
module osc_ctrl #(
   parameter int WDOG_FAIL_CYCLES = `OSC_WDOG_FAIL_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [15:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [15:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic crystal_disable_option,
   input wire logic [1:0] crystal_mode_option,
   input wire logic [7:0] trim_option,
   input wire logic primary_fail_pin,
   input wire logic wdog_osc_pin,
   output logic precision_rc_enable,
   output logic crystal_enable,
   output logic wdog_osc_enable,
   output logic [2:0] sysclk_source_select,
   output logic port_a_pin_zero_xtal,
   output logic port_a_pin_one_xtal,
   output logic [1:0] crystal_drive_mode,
   output logic [7:0] precision_rc_trim,
   output logic primary_fail_nmi,
   output logic wdog_fail_nmi,
   output logic recovery_active
);
   // Write channel holding registers; address and data may arrive in either order.
   logic aw_full_reg;
   logic [15:0] aw_addr_reg;
   logic w_full_reg;
   logic [7:0] w_data_reg;
   logic w_strb0_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   // Read channel answer registers.
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   // Register file and block state.
   logic [7:0] ctl_reg; // Oscillator control register.
   logic [7:0] ctl_next;
   osc_pkg::osc_lock_e lock_reg; // Unlock progress.
   osc_pkg::osc_lock_e lock_next;
   logic [7:0] trim_reg; // Precision RC trim value.
   logic boot_reg; // High for the first cycle after reset release.
   logic xhold_reg; // Crystal kept running from reset by the option bit.
   logic [1:0] xmode_reg; // Captured crystal drive mode.
   logic pfail_flag_reg; // Sticky primary failure flag.
   logic wfail_flag_reg; // Sticky watchdog failure flag.
   logic recov_reg; // Clock forced to the watchdog oscillator.
   logic recov_next;
   logic [2:0] src_reg; // Effective system clock source.
   logic pnmi_reg; // Primary failure event pulse.
   logic psync1_reg; // First stage, read only by the second.
   logic psync2_reg;
   logic plast_reg;
   logic wdmon_fail; // Watchdog monitor failure pulse.

   // Bus handshakes: a channel is ready while its holding register is free.
   assign awready = ~aw_full_reg;
   assign wready = ~w_full_reg;
   assign arready = ~rvalid_reg;
   wire do_wr = aw_full_reg & w_full_reg & ~bvalid_reg;
   wire do_rd = arvalid & ~rvalid_reg;

   // Address decode on the word index.
   wire [13:0] wr_idx = aw_addr_reg[15:2];
   wire [13:0] rd_idx = araddr[15:2];
   wire wr_ctl = wr_idx == `OSC_CTL_INDEX;
   wire wr_trim = wr_idx == `OSC_TRIM_INDEX;
   wire wr_stat = wr_idx == `OSC_STAT_INDEX;
   wire wr_hit = wr_ctl | wr_trim | wr_stat;
   wire rd_ctl = rd_idx == `OSC_CTL_INDEX;
   wire rd_trim = rd_idx == `OSC_TRIM_INDEX;
   wire rd_stat = rd_idx == `OSC_STAT_INDEX;
   wire rd_hit = rd_ctl | rd_trim | rd_stat;
   // Only the low byte holds data, so only byte lane 0 writes anything.
   wire do_ctl_wr = do_wr & wr_ctl & w_strb0_reg;
   wire do_trim_wr = do_wr & wr_trim & w_strb0_reg;
   wire do_stat_wr = do_wr & wr_stat & w_strb0_reg;
   wire commit = do_ctl_wr & (lock_reg == osc_pkg::osc_lk_open);

   // Primary failure qualification; while the watchdog failure flag is set no primary failure can be detected.
   wire prim_rise = psync2_reg & ~plast_reg;
   wire prim_evt = prim_rise & ctl_reg[`OSC_BIT_PFD_EN] & ~wfail_flag_reg;
   wire wdog_primary = src_reg == osc_pkg::osc_src_wdog;
   wire can_recover = ctl_reg[`OSC_BIT_WDOG_EN] & ~wdog_primary;
   // Watchdog detection is meaningless while that oscillator is off or drives the clock.
   wire wdmon_en = ctl_reg[`OSC_BIT_WFD_EN] & ctl_reg[`OSC_BIT_WDOG_EN] & ~wdog_primary;

   // Read data selection; the control register reads back in any lock state.
   wire [7:0] stat_val = {lock_reg == osc_pkg::osc_lk_open, lock_reg == osc_pkg::osc_lk_first,
      xmode_reg, crystal_enable, recov_reg, wfail_flag_reg, pfail_flag_reg};
   wire [7:0] rd_byte = rd_ctl ? ctl_reg : (rd_trim ? trim_reg : (rd_stat ? stat_val : 8'h00));

   // Capture address and data as each arrives; free both when the write executes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= 16'h0000;
      end else if (awvalid && !aw_full_reg) begin
         aw_full_reg <= 1'b1;
         aw_addr_reg <= awaddr;
      end else if (do_wr) begin
         aw_full_reg <= 1'b0;
      end
   end

   // Write data holding register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_reg <= 1'b0;
         w_data_reg <= 8'h00;
         w_strb0_reg <= 1'b0;
      end else if (wvalid && !w_full_reg) begin
         w_full_reg <= 1'b1;
         w_data_reg <= wdata[7:0];
         w_strb0_reg <= wstrb[0];
      end else if (do_wr) begin
         w_full_reg <= 1'b0;
      end
   end

   // Write response; an unmapped word answers with a slave error.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `OSC_RESP_OKAY;
      end else if (do_wr) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? `OSC_RESP_OKAY : `OSC_RESP_SLVERR;
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;

   // Read answer one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `OSC_RESP_OKAY;
      end else if (do_rd) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h000000, rd_byte};
         rresp_reg <= rd_hit ? `OSC_RESP_OKAY : `OSC_RESP_SLVERR;
      end else if (rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   // Unlock sequence. Only control register writes move it, so reads and other
   // registers leave the progress untouched. A repeated first key restarts cleanly.
   always_comb begin
      lock_next = lock_reg;
      ctl_next = ctl_reg;
      case (lock_reg)
         osc_pkg::osc_lk_locked: begin
            if (do_ctl_wr && w_data_reg == `OSC_UNLOCK_FIRST) begin
               lock_next = osc_pkg::osc_lk_first;
            end
         end
         osc_pkg::osc_lk_first: begin
            if (do_ctl_wr) begin
               if (w_data_reg == `OSC_UNLOCK_SECOND) begin
                  lock_next = osc_pkg::osc_lk_open;
               end else if (w_data_reg == `OSC_UNLOCK_FIRST) begin
                  lock_next = osc_pkg::osc_lk_first;
               end else begin
                  lock_next = osc_pkg::osc_lk_locked;
               end
            end
         end
         osc_pkg::osc_lk_open: begin
            if (do_ctl_wr) begin
               ctl_next = w_data_reg;
               lock_next = osc_pkg::osc_lk_locked;
            end
         end
         default: begin
            lock_next = osc_pkg::osc_lk_locked;
         end
      endcase
   end

   // Control register and lock state; the reset value enables both RC oscillators.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_reg <= `OSC_CTL_RESET;
         lock_reg <= osc_pkg::osc_lk_locked;
      end else begin
         ctl_reg <= ctl_next;
         lock_reg <= lock_next;
      end
   end

   // Option bits are caught one cycle after reset release, never under reset itself.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         boot_reg <= 1'b1;
         trim_reg <= `OSC_TRIM_RESET;
         xmode_reg <= osc_pkg::osc_xm_min;
         xhold_reg <= 1'b0;
      end else begin
         boot_reg <= 1'b0;
         if (boot_reg) begin
            trim_reg <= trim_option;
            xmode_reg <= crystal_mode_option;
            xhold_reg <= ~crystal_disable_option;
         end else begin
            if (do_trim_wr) begin
               trim_reg <= w_data_reg;
            end
            // The boot hold lapses at the first committed write; from then on the
            // crystal runs only while its enable bit says so.
            if (commit) begin
               xhold_reg <= 1'b0;
            end
         end
      end
   end

   // Primary failure pin from the analog detector, synchronised before use.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         psync1_reg <= 1'b0;
         psync2_reg <= 1'b0;
         plast_reg <= 1'b0;
      end else begin
         psync1_reg <= primary_fail_pin;
         psync2_reg <= psync1_reg;
         plast_reg <= psync2_reg;
      end
   end

   // Recovery holds until software commits a new control value; a failure in
   // the same cycle as that commit does not keep it, since can_recover is low while the watchdog is the source.
   assign recov_next = (prim_evt & can_recover) | (recov_reg & ~commit);

   // Failure flags, recovery and the effective source; set beats clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pfail_flag_reg <= 1'b0;
         wfail_flag_reg <= 1'b0;
         recov_reg <= 1'b0;
         src_reg <= osc_pkg::osc_src_prc_fast;
         pnmi_reg <= 1'b0;
      end else begin
         pfail_flag_reg <= prim_evt | (pfail_flag_reg & ~(do_stat_wr & w_data_reg[0]));
         wfail_flag_reg <= wdmon_fail | (wfail_flag_reg & ~(do_stat_wr & w_data_reg[1]));
         recov_reg <= recov_next;
         // Crystal code passes straight through: no divider on that path.
         src_reg <= recov_next ? osc_pkg::osc_src_wdog : ctl_next[2:0];
         pnmi_reg <= prim_evt;
      end
   end

   // Watchdog oscillator failure monitor.
   osc_wdmon #(
      .FAIL_CYCLES(WDOG_FAIL_CYCLES)
   ) u_wdmon (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(wdmon_en),
      .wdog_osc_pin(wdog_osc_pin),
      .fail_pulse(wdmon_fail)
   );

   // Oscillator controls. Software must let a freshly enabled crystal settle
   // before selecting it; the block does not delay the switch itself.
   assign precision_rc_enable = ctl_reg[`OSC_BIT_PRC_EN];
   assign crystal_enable = ctl_reg[`OSC_BIT_XTAL_EN] | xhold_reg;
   assign wdog_osc_enable = ctl_reg[`OSC_BIT_WDOG_EN];
   assign port_a_pin_zero_xtal = crystal_enable;
   assign port_a_pin_one_xtal = crystal_enable;
   assign sysclk_source_select = src_reg;
   assign crystal_drive_mode = xmode_reg;
   assign precision_rc_trim = trim_reg;
   assign primary_fail_nmi = pnmi_reg;
   assign wdog_fail_nmi = wdmon_fail;
   assign recovery_active = recov_reg;

   property p_change_needs_unlock;
      @(posedge aclk) disable iff (!aresetn)
      $changed(ctl_reg) |-> $past(commit);
   endproperty
   a_change_needs_unlock: assert property (p_change_needs_unlock) else $error("locked change");
   property p_relock;
      @(posedge aclk) disable iff (!aresetn)
      commit |=> lock_reg == osc_pkg::osc_lk_locked && ctl_reg == $past(w_data_reg);
   endproperty
   a_relock: assert property (p_relock) else $error("no relock after commit");
   property p_no_effect;
      @(posedge aclk) disable iff (!aresetn)
      (do_ctl_wr && lock_reg != osc_pkg::osc_lk_open) |=> $stable(ctl_reg);
   endproperty
   a_no_effect: assert property (p_no_effect) else $error("write while locked changed register");
   property p_other_keeps;
      @(posedge aclk) disable iff (!aresetn)
      (do_wr && !wr_ctl) |=> $stable(lock_reg);
   endproperty
   a_other_keeps: assert property (p_other_keeps) else $error("other write broke unlock");
   property p_reset_val;
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> ctl_reg == `OSC_CTL_RESET && lock_reg == osc_pkg::osc_lk_locked;
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("bad control reset value");
   property p_primary_fail_detect_enable_gate;
      @(posedge aclk) disable iff (!aresetn)
      primary_fail_nmi |-> $past(ctl_reg[`OSC_BIT_PFD_EN]);
   endproperty
   a_primary_fail_detect_enable_gate: assert property (p_primary_fail_detect_enable_gate) else $error("event while detection off");
   property p_recover;
      @(posedge aclk) disable iff (!aresetn)
      (prim_evt && can_recover) |=> primary_fail_nmi && recovery_active
         && sysclk_source_select == osc_pkg::osc_src_wdog;
   endproperty
   a_recover: assert property (p_recover) else $error("no switch to watchdog");
   property p_trim_write;
      @(posedge aclk) disable iff (!aresetn)
      (do_trim_wr && !boot_reg) |=> precision_rc_trim == $past(w_data_reg);
   endproperty
   a_trim_write: assert property (p_trim_write) else $error("trim override lost");
   property p_read_keeps;
      @(posedge aclk) disable iff (!aresetn)
      (do_rd && !do_wr) |=> $stable(lock_reg) && $stable(ctl_reg);
   endproperty
   a_read_keeps: assert property (p_read_keeps) else $error("read altered lock state");
endmodule

// >>> hw/osc_cfg.svh
// Constants for the oscillator control block: offsets, field positions, resets, timing.
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH
// Register indexes; the byte address is four times the index.
`define OSC_CTL_INDEX 14'h0f86
`define OSC_TRIM_INDEX 14'h0f87
`define OSC_STAT_INDEX 14'h0f88
// Control register reset value, unlock keys and trim reset value.
`define OSC_CTL_RESET 8'ha0
`define OSC_UNLOCK_FIRST 8'he7
`define OSC_UNLOCK_SECOND 8'h18
`define OSC_TRIM_RESET 8'h00
// Control register field positions.
`define OSC_BIT_PRC_EN 7
`define OSC_BIT_XTAL_EN 6
`define OSC_BIT_WDOG_EN 5
`define OSC_BIT_PFD_EN 4
`define OSC_BIT_WFD_EN 3
`define OSC_SEL_MSB 2
`define OSC_SEL_LSB 0
// Status register field positions.
`define OSC_STAT_PFAIL 0
`define OSC_STAT_WFAIL 1
`define OSC_STAT_RECOV 2
`define OSC_STAT_XRUN 3
`define OSC_STAT_MODE_LSB 4
`define OSC_STAT_MODE_MSB 5
`define OSC_STAT_FIRST 6
`define OSC_STAT_OPEN 7
// System clock cycles without a watchdog clock edge before a failure is declared.
`define OSC_WDOG_FAIL_CYCLES 8004
// AXI response codes.
`define OSC_RESP_OKAY 2'h0
`define OSC_RESP_SLVERR 2'h2
`endif

// >>> hw/osc_pkg.sv
// Types shared by the oscillator control block.
package osc_pkg;
   // System clock source codes; codes 5 to 7 are reserved.
   typedef enum logic [2:0] {
      osc_src_prc_fast = 3'h0,
      osc_src_prc_slow = 3'h1,
      osc_src_crystal = 3'h2,
      osc_src_wdog = 3'h3,
      osc_src_ext_pin = 3'h4
   } osc_src_e;
   // Unlock progress, one-hot.
   typedef enum logic [2:0] {
      osc_lk_locked = 3'h1,
      osc_lk_first = 3'h2,
      osc_lk_open = 3'h4
   } osc_lock_e;
   // Crystal drive modes from the option bits.
   typedef enum logic [1:0] {
      osc_xm_min = 2'h0,
      osc_xm_med = 2'h1,
      osc_xm_max = 2'h2,
      osc_xm_rc = 2'h3
   } osc_xmode_e;
endpackage

// >>> hw/osc_wdmon.sv
// Watchdog oscillator failure monitor counting system clocks between watchdog edges.
`timescale 1ns/1ps
`include "osc_cfg.svh"
module osc_wdmon #(
   parameter int FAIL_CYCLES = `OSC_WDOG_FAIL_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic enable,
   input wire logic wdog_osc_pin,
   output logic fail_pulse
);
   localparam logic [13:0] LIMIT = 14'(FAIL_CYCLES - 1);
   logic sync1_reg; // First synchroniser stage, read only by the second.
   logic sync2_reg; // Second synchroniser stage.
   logic last_reg; // Previous synchronised level for edge detection.
   logic [13:0] cnt_reg; // Cycles since the last watchdog edge.
   logic fired_reg; // Failure already reported since the last edge.
   logic fail_reg; // Registered failure pulse.
   wire edge_seen = sync2_reg & ~last_reg;
   wire at_limit = enable & ~edge_seen & ~fired_reg & (cnt_reg == LIMIT);

   // Bring the asynchronous watchdog clock into the system clock domain.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         sync1_reg <= wdog_osc_pin;
         sync2_reg <= sync1_reg;
         last_reg <= sync2_reg;
      end
   end

   // Count while waiting; any rising edge or a disable restarts the wait.
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable || edge_seen) begin
         cnt_reg <= 14'h0000;
         fired_reg <= 1'b0;
      end else if (at_limit) begin
         fired_reg <= 1'b1;
      end else if (!fired_reg) begin
         cnt_reg <= cnt_reg + 14'h0001;
      end
   end

   // One pulse per failure; a stopped oscillator is reported once, not every window.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fail_reg <= 1'b0;
      end else begin
         fail_reg <= at_limit;
      end
   end
   assign fail_pulse = fail_reg;

   property p_wdog_limit;
      @(posedge aclk) disable iff (!aresetn)
      (enable && !edge_seen && !fired_reg && cnt_reg == LIMIT) |=> fail_pulse;
   endproperty
   a_wdog_limit: assert property (p_wdog_limit) else $error("watchdog failure not flagged");
endmodule

// >>> bench/osc_far_side.sv
// Far-side model: watchdog oscillator clock and primary failure detector level.
`timescale 1ns/1ps
module osc_far_side (
   input wire logic wdog_run,
   input wire logic fail_primary,
   output logic wdog_osc_pin,
   output logic primary_fail_pin
);
   // Slow watchdog clock; a stall holds it low, as a dead oscillator would.
   initial begin
      wdog_osc_pin = 1'b0;
      forever begin
         #30;
         wdog_osc_pin = wdog_run ? ~wdog_osc_pin : 1'b0;
      end
   end
   // The detector level simply follows the commanded fault.
   assign primary_fail_pin = fail_primary;
endmodule

// >>> bench/oscillator_control_select_tb_top.sv
// Self-checking bench for the oscillator control block.
`timescale 1ns/1ps
`include "osc_cfg.svh"
module oscillator_control_select_tb_top;
   localparam int WFC = 20; // Shortened stall count keeps the run brief.
   localparam logic [15:0] A_CTL = {`OSC_CTL_INDEX, 2'h0};
   localparam logic [15:0] A_TRIM = {`OSC_TRIM_INDEX, 2'h0};
   localparam logic [15:0] A_STAT = {`OSC_STAT_INDEX, 2'h0};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [15:0] awaddr = 16'h0, araddr = 16'h0;
   logic [31:0] wdata = 32'h0;
   logic wdog_run = 1'b1, fail_primary = 1'b0;
   logic xdis_opt = 1'b0; // Crystal disable option bit, changed only under reset.
   logic awready, wready, bvalid, arready, rvalid, wdog_osc_pin, primary_fail_pin;
   logic [1:0] bresp, rresp, crystal_drive_mode;
   logic [31:0] rdata;
   logic precision_rc_enable, crystal_enable, wdog_osc_enable, port_a_pin_zero_xtal;
   logic port_a_pin_one_xtal, primary_fail_nmi, wdog_fail_nmi, recovery_active;
   logic [2:0] sysclk_source_select;
   logic [7:0] precision_rc_trim;
   int n_fail = 0;
   int checked = 0;
   // Free-running 40 MHz clock.
   always #12.5 aclk = ~aclk;
   osc_ctrl #(.WDOG_FAIL_CYCLES(WFC)) i_osc_ctrl (.aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .crystal_disable_option(xdis_opt), .crystal_mode_option(2'h2), .trim_option(8'h3c),
      .primary_fail_pin(primary_fail_pin), .wdog_osc_pin(wdog_osc_pin),
      .precision_rc_enable(precision_rc_enable), .crystal_enable(crystal_enable),
      .wdog_osc_enable(wdog_osc_enable), .sysclk_source_select(sysclk_source_select),
      .port_a_pin_zero_xtal(port_a_pin_zero_xtal), .port_a_pin_one_xtal(port_a_pin_one_xtal),
      .crystal_drive_mode(crystal_drive_mode), .precision_rc_trim(precision_rc_trim),
      .primary_fail_nmi(primary_fail_nmi), .wdog_fail_nmi(wdog_fail_nmi),
      .recovery_active(recovery_active));
   osc_far_side i_osc_far_side (.wdog_run(wdog_run), .fail_primary(fail_primary),
      .wdog_osc_pin(wdog_osc_pin), .primary_fail_pin(primary_fail_pin));
   // Compares one value and counts the result.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One bus write; each channel is released only at its own handshake edge.
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      while (n < 50) begin
         @(posedge aclk);
         n++;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            bready <= 1'b0;
            chk(32'(bresp), 32'(er));
            n = 99;
         end
      end
      // A missing answer counts as a mismatch.
      if (n != 99) n_fail++;
      #1;
   endtask
   // One bus read; data and response are taken at the handshake edge.
   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (n < 50) begin
         @(posedge aclk);
         n++;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rready <= 1'b0;
            d = rdata;
            r = rresp;
            n = 99;
         end
      end
      if (n != 99) n_fail++;
      #1;
   endtask
   // Full key sequence then the data write.
   task automatic ctl_set(input logic [7:0] v);
      wr(A_CTL, 32'he7, 2'h0);
      wr(A_CTL, 32'h18, 2'h0);
      wr(A_CTL, {24'h0, v}, 2'h0);
   endtask
   // Counts failure pulses of one kind over a number of cycles.
   task automatic count_nmi(input int cyc, input bit wd, output int hits);
      hits = 0;
      repeat (cyc) begin
         @(posedge aclk);
         if ((wd ? wdog_fail_nmi : primary_fail_nmi) === 1'b1) hits++;
      end
   endtask
   // Reset values of the register and of the option-driven outputs.
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      rd(A_CTL, d, r);
      chk(d, 32'ha0);
      chk(32'(precision_rc_enable), 32'h1);
      chk(32'(wdog_osc_enable), 32'h1);
      chk(32'(crystal_enable), 32'h1);
      chk(32'(crystal_drive_mode), 32'h2);
      chk(32'(precision_rc_trim), 32'h3c);
   endtask
   // Locked writes, interleaved accesses, relock and broken key orders.
   task automatic t_lock;
      logic [31:0] d;
      logic [1:0] r;
      wr(A_CTL, 32'h55, 2'h0);
      rd(A_CTL, d, r);
      chk(d, 32'ha0);
      wr(A_CTL, 32'he7, 2'h0);
      rd(A_CTL, d, r);
      chk(d, 32'ha0);
      wr(A_TRIM, 32'h5a, 2'h0);
      wr(A_CTL, 32'h18, 2'h0);
      wr(A_CTL, 32'hc1, 2'h0);
      rd(A_CTL, d, r);
      chk(d, 32'hc1);
      chk(32'(port_a_pin_zero_xtal & port_a_pin_one_xtal), 32'h1);
      rd(A_TRIM, d, r);
      chk(d, 32'h5a);
      chk(32'(precision_rc_trim), 32'h5a);
      wr(A_CTL, 32'h00, 2'h0);
      wr(A_CTL, 32'he7, 2'h0);
      wr(A_CTL, 32'h55, 2'h0);
      wr(A_CTL, 32'h18, 2'h0);
      wr(A_CTL, 32'h00, 2'h0);
      rd(A_CTL, d, r);
      chk(d, 32'hc1);
      // The crystal is never selected here, so no settle wait is owed.
      ctl_set(8'ha0);
      chk(32'(crystal_enable | port_a_pin_zero_xtal), 32'h0);
   endtask
   // Every select code, reserved ones included, and unmapped accesses.
   task automatic t_select;
      logic [31:0] d;
      logic [1:0] r;
      for (int c = 0; c < 8; c++) begin
         ctl_set({5'h10, 3'(c)});
         chk(32'(sysclk_source_select), 32'(c));
      end
      rd(16'h0100, d, r);
      chk({d[31:2], r}, 32'h2);
      wr(16'h0104, 32'h1, 2'h2);
   endtask
   // Primary failure ignored when disabled, recovered when enabled.
   task automatic t_primary;
      logic [31:0] d;
      logic [1:0] r;
      int h;
      ctl_set(8'ha0);
      @(posedge aclk) fail_primary <= 1'b1;
      count_nmi(10, 1'b0, h);
      chk(32'(h), 32'h0);
      @(posedge aclk) fail_primary <= 1'b0;
      ctl_set(8'hb0);
      @(posedge aclk) fail_primary <= 1'b1;
      count_nmi(10, 1'b0, h);
      chk(32'(h), 32'h1);
      chk(32'(sysclk_source_select), 32'h3);
      chk(32'(recovery_active), 32'h1);
      rd(A_STAT, d, r);
      chk(d & 32'h05, 32'h05);
      @(posedge aclk) fail_primary <= 1'b0;
      ctl_set(8'ha8);
      chk(32'(recovery_active) + 32'(sysclk_source_select), 32'h0);
   endtask
   // Watchdog stall: no pulse while running, one pulse at the count, none when off.
   task automatic t_wdog;
      logic [31:0] d;
      logic [1:0] r;
      int h;
      count_nmi(60, 1'b1, h);
      chk(32'(h), 32'h0);
      @(posedge aclk) wdog_run <= 1'b0;
      count_nmi(14, 1'b1, h);
      chk(32'(h), 32'h0);
      count_nmi(16, 1'b1, h);
      chk(32'(h), 32'h1);
      count_nmi(30, 1'b1, h);
      chk(32'(h), 32'h0);
      rd(A_STAT, d, r);
      chk(d & 32'h02, 32'h02);
      ctl_set(8'ha0);
      count_nmi(30, 1'b1, h);
      chk(32'(h), 32'h0);
   endtask
   // Second reset with the crystal disable option set: the crystal must stay off.
   task automatic t_option;
      @(posedge aclk);
      xdis_opt <= 1'b1;
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(32'(crystal_enable), 32'h0);
      chk(32'(precision_rc_enable), 32'h1);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Main sequence: reset for six cycles, then the scenarios in order.
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_lock();
      t_select();
      t_primary();
      t_wdog();
      t_option();
      tally_and_finish();
   end
   // Hang guard, well beyond the expected run of a few hundred cycles.
   initial begin
      #200000;
      n_fail++;
      tally_and_finish();
   end
endmodule
